// ---- dpsc_top.v ----
// dpsc_top.v - serial control port of a dual digital potentiometer
// assumes all pins are asynchronous to clk and sck runs well below clk / 4
//
// Behaviour
// R1 - sample serial input on each rising serial clock edge while select is low
// R2 - command and data bytes share one shift register
// R3 - serial output updates on each falling serial clock edge with shifted-out bit
// R4 - serial output is push-pull, never floats, and is low while select is high
// R5 - the loaded command is executed only when select returns high
// R6 - with select high, clock and data toggling change no state
// R7 - reset pin low at least 150 ns sets all wipers to 80h
// R8 - controller lowers reset or shutdown pins only while select is high
// R9 - reset pulse is honoured even while the shutdown pin is low
// R10 - shutdown pin low puts every pot in power-saving state
// R11 - reset or shutdown low pulse of 150 ns exits software shutdown
// R12 - wipers load mid-scale 80h at power-up
// R13 - shutdown leaves wiper data intact; writes in shutdown take effect after
// R14 - each pot holds an 8-bit wiper code, 00h at terminal b
`timescale 1ns/100ps
`include "dpsc_map.vh"
module dpsc_top (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       cs_n,
    input  wire       sck,
    input  wire       si,
    input  wire       wiper_reset_n,
    input  wire       pot_shutdown_n,
    output reg        so_reg,
    output reg  [7:0] wiper0_reg,
    output reg  [7:0] wiper1_reg,
    output reg  [1:0] pot_pot_shutdown_n_reg
);
    // the header figure is an integer; cut it to the counter width on purpose
    localparam [31:0]             PULSE_CYC_FULL = `DPSC_PULSE_CYC;
    localparam [`DPSC_PCNT_W-1:0] PULSE_CYC      = PULSE_CYC_FULL[`DPSC_PCNT_W-1:0];

    // ************************************************************
    // reset release
    // ************************************************************
    reg rst_meta_reg;
    reg rst_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_reg      <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_reg      <= rst_meta_reg;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [4:0] pins_s;
    wire       cs_n_s;
    wire       sck_s;
    wire       si_s;
    wire       wrst_n_s;
    wire       pot_shutdown_n_n_s;

    // start at the idle pin levels so no false edge or pin pulse follows reset
    dpsc_sync #(
        .WIDTH (5),
        .INIT  (5'h13)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_reg),
        .d     ({cs_n, sck, si, wiper_reset_n, pot_shutdown_n}),
        .q     (pins_s)
    );

    assign cs_n_s   = pins_s[4];
    assign sck_s    = pins_s[3];
    assign si_s     = pins_s[2];
    assign wrst_n_s = pins_s[1];
    assign pot_shutdown_n_n_s = pins_s[0];

    // ************************************************************
    // edge detection
    // ************************************************************
    reg  sck_prev_reg;
    reg  cs_prev_reg;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire cs_fall;

    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg  <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s;
            cs_prev_reg  <= cs_n_s;
        end
    end

    // edges only count while selected; toggling with select high is dropped
    assign sck_rise = !cs_n_s && sck_s && !sck_prev_reg;   // [R6]
    assign sck_fall = !cs_n_s && !sck_s && sck_prev_reg;   // [R6]
    assign cs_rise  = cs_n_s && !cs_prev_reg;
    assign cs_fall  = !cs_n_s && cs_prev_reg;

    // ************************************************************
    // shift register and bit count
    // ************************************************************
    reg [`DPSC_FRAME_BITS-1:0] shift_reg;
    reg [`DPSC_BCNT_W-1:0]     bcnt_reg;
    reg                        frame_reg;
    reg                        out_bit_reg;

    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            shift_reg   <= `DPSC_SHIFT_RST;
            bcnt_reg    <= {`DPSC_BCNT_W{1'b0}};
            frame_reg   <= 1'b0;
            out_bit_reg <= 1'b0;
        end else if (cs_fall) begin
            bcnt_reg  <= {`DPSC_BCNT_W{1'b0}};
            frame_reg <= 1'b0;
        end else if (sck_rise) begin
            // msb leaves for the next device in the chain as si enters
            out_bit_reg <= shift_reg[`DPSC_FRAME_BITS-1];
            shift_reg   <= {shift_reg[`DPSC_FRAME_BITS-2:0], si_s};   // [R1] [R2]
            bcnt_reg    <= bcnt_reg + 4'h1;
            if (bcnt_reg == 4'hf) begin
                frame_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // serial output
    // ************************************************************
    // so is a plain output; it never floats
    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            so_reg <= 1'b0;
        end else if (cs_n_s) begin
            so_reg <= 1'b0;                                     // [R4]
        end else if (sck_fall) begin
            so_reg <= out_bit_reg;                              // [R3]
        end
    end

    // ************************************************************
    // hardware pin pulse width qualification
    // ************************************************************
    // a low shorter than the minimum raises neither pulse; the pots still follow the shutdown pin directly
    reg [`DPSC_PCNT_W-1:0] rcnt_reg;
    reg [`DPSC_PCNT_W-1:0] scnt_reg;
    wire                   rst_pulse;
    wire                   pot_shutdown_n_pulse;

    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            rcnt_reg <= {`DPSC_PCNT_W{1'b0}};
            scnt_reg <= {`DPSC_PCNT_W{1'b0}};
        end else begin
            if (wrst_n_s) begin
                rcnt_reg <= {`DPSC_PCNT_W{1'b0}};
            end else if (rcnt_reg != PULSE_CYC) begin
                rcnt_reg <= rcnt_reg + 3'h1;
            end
            if (pot_shutdown_n_n_s) begin
                scnt_reg <= {`DPSC_PCNT_W{1'b0}};
            end else if (scnt_reg != PULSE_CYC) begin
                scnt_reg <= scnt_reg + 3'h1;
            end
        end
    end

    // held low for the full minimum time
    assign rst_pulse  = (rcnt_reg == PULSE_CYC);                // [R7]
    assign pot_shutdown_n_pulse = (scnt_reg == PULSE_CYC);

    // ************************************************************
    // command decode, executed on select rising
    // ************************************************************
    wire       exec;
    wire [1:0] cmd;
    wire       sel0;
    wire       sel1;
    wire [7:0] data;

    // daisy chains deliver whole multiples of a frame; the last one is ours
    assign exec = cs_rise && frame_reg && (bcnt_reg == 4'h0);   // [R5]
    assign cmd  = shift_reg[`DPSC_CMD_HI:`DPSC_CMD_LO];
    assign sel0 = shift_reg[`DPSC_SEL0_BIT];
    assign sel1 = shift_reg[`DPSC_SEL1_BIT];
    assign data = shift_reg[`DPSC_DATA_HI:0];

    // ************************************************************
    // wiper data registers
    // ************************************************************
    // the reset pin wins over a frame ending in the same cycle; the
    // controller keeps the pin high while selected, so no frame is lost
    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            wiper0_reg <= `DPSC_MIDSCALE;                       // [R12] [R14]
            wiper1_reg <= `DPSC_MIDSCALE;                       // [R12]
        end else if (rst_pulse) begin
            // not gated by shutdown
            wiper0_reg <= `DPSC_MIDSCALE;                       // [R7] [R9] [R8]
            wiper1_reg <= `DPSC_MIDSCALE;                       // [R7]
        end else if (exec && (cmd == `DPSC_CMD_WRITE)) begin
            // writes go through in shutdown too
            if (sel0) begin
                wiper0_reg <= data;                             // [R13] [R14]
            end
            if (sel1) begin
                wiper1_reg <= data;                             // [R13]
            end
        end
    end

    // ************************************************************
    // software and hardware shutdown
    // ************************************************************
    reg  [1:0] sw_pot_shutdown_n_reg;
    wire [1:0] sel_mask;

    assign sel_mask = {sel1, sel0};

    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            sw_pot_shutdown_n_reg <= 2'h0;
        end else if (rst_pulse || pot_shutdown_n_pulse) begin
            sw_pot_shutdown_n_reg <= 2'h0;                                // [R11]
        end else if (exec && (cmd == `DPSC_CMD_POT_SHUTDOWN_N)) begin
            sw_pot_shutdown_n_reg <= sw_pot_shutdown_n_reg | sel_mask;
        end else if (exec && (cmd == `DPSC_CMD_WRITE)) begin
            // a write brings the selected pots back to their new code
            sw_pot_shutdown_n_reg <= sw_pot_shutdown_n_reg & ~sel_mask;
        end
    end

    // shutdown state never touches the wiper codes
    always @(posedge clk or negedge rst_reg) begin
        if (!rst_reg) begin
            pot_pot_shutdown_n_reg <= 2'h0;
        end else begin
            pot_pot_shutdown_n_reg <= sw_pot_shutdown_n_reg | {2{!pot_shutdown_n_n_s}};       // [R10] [R13]
        end
    end
endmodule // dpsc_top

// ---- dpsc_map.vh ----
// dpsc_map.vh - constants of the digital potentiometer serial control block
// assumes inclusion by bare name from the design files of this block
`ifndef DPSC_MAP_VH
`define DPSC_MAP_VH

// ************************************************************
// clock and pulse timing
// ************************************************************
`define DPSC_CLK_MHZ        40
`define DPSC_PULSE_MIN_NS   150
// least time rounds up to whole cycles
`define DPSC_PULSE_CYC      ((`DPSC_PULSE_MIN_NS * `DPSC_CLK_MHZ + 999) / 1000)
`define DPSC_PCNT_W         3

// ************************************************************
// frame layout: command byte then data byte, msb first
// ************************************************************
`define DPSC_FRAME_BITS     16
`define DPSC_BCNT_W         4
`define DPSC_CMD_HI         13
`define DPSC_CMD_LO         12
`define DPSC_SEL1_BIT       9
`define DPSC_SEL0_BIT       8
`define DPSC_DATA_HI        7

// ************************************************************
// command codes
// ************************************************************
`define DPSC_CMD_WRITE      2'h1
`define DPSC_CMD_POT_SHUTDOWN_N       2'h2

// ************************************************************
// reset values
// ************************************************************
`define DPSC_MIDSCALE       8'h80
`define DPSC_SHIFT_RST      16'h0000

`endif

// ---- dpsc_sync.v ----
// dpsc_sync.v - two flip-flop synchroniser for a group of pin levels
// assumes the levels are asynchronous to clk; output is safe for logic
`timescale 1ns/100ps
module dpsc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // first stage is read by the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule // dpsc_sync

// ---- dpsc_top_assertions.sv ----
// dpsc_top_assertions.sv - port checker for the serial control block
// assumes pins move just after clk rises and reset pins fall only with cs_n high
`timescale 1ns/100ps
module dpsc_top_chk (
    input wire       clk,
    input wire       reset_n,
    input wire       cs_n,
    input wire       sck,
    input wire       si,
    input wire       wiper_reset_n,
    input wire       pot_shutdown_n,
    input wire       so_reg,
    input wire [7:0] wiper0_reg,
    input wire [7:0] wiper1_reg,
    input wire [1:0] pot_pot_shutdown_n_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_so_idle;
        cs_n [*4] |-> so_reg == 1'b0;
    endproperty
    a_so_idle: assert property (p_so_idle) else $error("so not low while deselected");
    // windows are wide enough for either reading of the three-edge latency
    property p_so_on_fall;
        $changed(so_reg) |-> $past(cs_n, 2) || $past(cs_n, 4) || ($past(sck, 4) && !$past(sck, 2));
    endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("so moved without sck fall");
    property p_pin_shutdown;
        !pot_shutdown_n [*4] |-> pot_pot_shutdown_n_reg == 2'h3;
    endproperty
    a_pin_shutdown: assert property (p_pin_shutdown) else $error("pots not shut down");
    property p_pot_shutdown_n_keeps_data;
        $fell(pot_shutdown_n) && cs_n && wiper_reset_n |=> $stable({wiper1_reg, wiper0_reg}) [*4];
    endproperty
    a_pot_shutdown_n_keeps_data: assert property (p_pot_shutdown_n_keeps_data) else $error("shutdown moved wiper");
    property p_idle_holds;
        (cs_n && wiper_reset_n) [*8] |-> $stable({wiper1_reg, wiper0_reg});
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("wiper moved while idle");
    property p_exec_at_rise;
        (!cs_n && wiper_reset_n) [*4] |-> $stable({wiper1_reg, wiper0_reg, pot_pot_shutdown_n_reg});
    endproperty
    a_exec_at_rise: assert property (p_exec_at_rise) else $error("state moved mid-frame");
    property p_pin_reset_mid;
        !wiper_reset_n [*8] ##1 !wiper_reset_n [*3] |-> wiper0_reg == 8'h80 && wiper1_reg == 8'h80;
    endproperty
    a_pin_reset_mid: assert property (p_pin_reset_mid) else $error("wipers not mid-scale");
    property p_pin_reset_wakes;
        (!wiper_reset_n && pot_shutdown_n) [*8] ##1 !wiper_reset_n [*3] |-> pot_pot_shutdown_n_reg == 2'h0;
    endproperty
    a_pin_reset_wakes: assert property (p_pin_reset_wakes) else $error("pot still shut down");
endmodule // dpsc_top_chk

bind dpsc_top dpsc_top_chk dpsc_top_chk_inst (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .sck(sck), .si(si), .wiper_reset_n(wiper_reset_n), .pot_shutdown_n(pot_shutdown_n),
    .so_reg(so_reg), .wiper0_reg(wiper0_reg), .wiper1_reg(wiper1_reg),
    .pot_pot_shutdown_n_reg(pot_pot_shutdown_n_reg));

// ---- dpsc_spi_host.sv ----
// dpsc_spi_host.sv - behavioural serial host driving the link in mode 0
// assumes callers enter its tasks 1 ns after a clk rise
`timescale 1ns/100ps
module dpsc_spi_host (
    input  wire  clk,
    input  wire  so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic so_q[$];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // so_q[m] holds so after m rises; sampled just before the next rise
    task send(input logic [31:0] d, input int n);
        so_q.delete();
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i]; // msb first, set 100 ns before the rise
            tick(4);
            so_q.push_back(so);
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        so_q.push_back(so);
        cs_n = 1'b1;
        // released line shows no stale bit
        si = ~si;
        tick(8);
    endtask
    // activity on sck and si while deselected
    task noise(input int n);
        repeat (n) begin
            sck = ~sck;
            si = ~si;
            tick(2);
        end
    endtask
endmodule // dpsc_spi_host

// ---- digipot_serial_control_tb.sv ----
// digipot_serial_control_tb.sv - self-checking bench for dpsc_top
// assumes dpsc_spi_host drives the link; pins move 1 ns after clk rises
`timescale 1ns/100ps
module digipot_serial_control_tb;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       wiper_reset_n = 1'b1;
    logic       pot_shutdown_n = 1'b1;
    wire        cs_n, sck, si, so_reg;
    wire  [7:0] wiper0_reg, wiper1_reg;
    wire  [1:0] pot_pot_shutdown_n_reg;
    int         errors = 0;
    int         tests_run = 0;
    int         seed = 32'h44442828;
    logic [7:0] w[2] = '{8'h80, 8'h80};
    logic [1:0] sw = 2'h0;
    always #12.5 clk = ~clk;
    dpsc_top dpsc_top_inst (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
        .wiper_reset_n(wiper_reset_n), .pot_shutdown_n(pot_shutdown_n), .so_reg(so_reg),
        .wiper0_reg(wiper0_reg), .wiper1_reg(wiper1_reg), .pot_pot_shutdown_n_reg(pot_pot_shutdown_n_reg));
    dpsc_spi_host dpsc_spi_host_inst (.clk(clk), .so(so_reg), .cs_n(cs_n), .sck(sck), .si(si));
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmp;
        check("wiper0", wiper0_reg, w[0]);
        check("wiper1", wiper1_reg, w[1]);
        check("pot_pot_shutdown_n", {6'h0, pot_pot_shutdown_n_reg}, {6'h0, sw | {2{~pot_shutdown_n}}});
        check("so_idle", {7'h0, so_reg}, 8'h0);
    endtask
    // only whole 16-bit frames act, and only the last 16 bits of a chain
    task frame(input logic [31:0] d, input int n);
        dpsc_spi_host_inst.send(d, n);
        if (n % 16 == 0 && d[13:12] == 2'h1) begin
            for (int p = 0; p < 2; p++)
                if (d[8 + p]) begin
                    w[p] = d[7:0];
                    sw[p] = 1'b0;
                end
        end
        if (n % 16 == 0 && d[13:12] == 2'h2)
            sw = sw | d[9:8];
        for (int m = 17; m <= n; m++)
            check("so_bit", {7'h0, dpsc_spi_host_inst.so_q[m]}, {7'h0, d[48 - m]});
        cmp();
    endtask
    task pulse_reset(input int len);
        wiper_reset_n = 1'b0; // cs_n is high between frames
        dpsc_spi_host_inst.tick(len);
        wiper_reset_n = 1'b1;
        dpsc_spi_host_inst.tick(8);
        if (len >= 6) begin
            w = '{8'h80, 8'h80};
            sw = 2'h0;
        end
        cmp();
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        dpsc_spi_host_inst.tick(8);
        cmp();
        frame(32'h1100, 16);
        frame(32'h12ff, 16);
        repeat (4)
            frame({16'h0, 6'h04, 1'b1, 1'($random(seed)), 8'($random(seed))}, 16);
        for (int c = 0; c < 4; c++)
            frame({18'h0, 2'(c), 12'h23c}, 16);
        frame({16'($random(seed)), 16'h1303}, 32);
        frame(32'h1f3c, 15);
        dpsc_spi_host_inst.noise(12);
        cmp();
        frame(32'h2100, 16);
        pulse_reset(3);
        pulse_reset(12);
        frame(32'h2300, 16);
        pot_shutdown_n = 1'b0;
        dpsc_spi_host_inst.tick(8);
        sw = 2'h0;
        cmp();
        frame(32'h1277, 16);
        pulse_reset(12);
        frame(32'h1166, 16);
        pot_shutdown_n = 1'b1;
        dpsc_spi_host_inst.tick(8);
        cmp();
        give_verdict();
    end
endmodule // digipot_serial_control_tb
